// >>> hdl/clm_pkg.sv
// Package of offsets, field positions, reset values and timing for the lock/ppm monitor
package clm_pkg;
  // Register offsets (channel register space, 8-bit registers)
  localparam logic [7:0] CLM_OFS_LOCK_CTRL  = 8'h34;  // Lock supervision control
  localparam logic [7:0] CLM_OFS_PPM_CTRL   = 8'h35;  // Tolerance scale and measure control
  localparam logic [7:0] CLM_OFS_PPM_ERR_LO = 8'h3b;  // Ppm error result, low byte
  localparam logic [7:0] CLM_OFS_PPM_ERR_HI = 8'h3c;  // Ppm error result, high byte
  localparam logic [7:0] CLM_OFS_PPM_DELTA  = 8'h64;  // Ppm delta tolerance base
  // Field positions
  localparam int CLM_BIT_PPM_RDY   = 7;  // Ready flag in lock control register
  localparam int CLM_BIT_RETRY_HI  = 5;  // lock_retry_count_hi
  localparam int CLM_BIT_RETRY_LO  = 4;  // lock_retry_count_lo
  localparam int CLM_BIT_SCALE_HI  = 7;  // tolerance_scale_hi
  localparam int CLM_BIT_SCALE_LO  = 6;  // tolerance_scale_lo
  localparam int CLM_BIT_GET_PPM   = 5;  // Manual capture trigger
  // Reset values
  localparam logic [7:0] CLM_RST_LOCK_CTRL = 8'h3f;
  localparam logic [7:0] CLM_RST_PPM_CTRL  = 8'h1f;
  localparam logic [7:0] CLM_RST_DELTA     = 8'h00;
  // Lock check spacing in ns and derived cycle count at 50 MHz
  localparam int CLM_CLK_NS         = 20;
  localparam int CLM_CHECK_NS       = 1000;
  localparam int CLM_CHECK_CYC      = (CLM_CHECK_NS / CLM_CLK_NS < 1) ? 1
                                      : CLM_CHECK_NS / CLM_CLK_NS;
  // Continuous ppm refresh interval
  localparam int CLM_REFRESH_NS     = 10000;
  localparam int CLM_REFRESH_CYC    = CLM_REFRESH_NS / CLM_CLK_NS;
  typedef enum logic [1:0] {CLM_UNLOCKED, CLM_LOCKED, CLM_RECHECK} clm_lock_st_t;
endpackage

// >>> hdl/clm_tick.sv
// Divider producing a one-cycle enable pulse every PERIOD clocks
`timescale 1ns/1ps
module clm_tick #(
  parameter int PERIOD = 50
) (
  input  wire logic ref_clk,  // System clock
  input  wire logic rst,      // Synchronous reset, active high
  output logic      tick      // One-cycle pulse
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  // Count down and wrap, pulsing at zero
  always_comb begin
    cnt_next = (cnt_reg == 16'h0000) ? 16'(PERIOD - 1) : cnt_reg - 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = (cnt_reg == 16'h0000) && !rst;
endmodule

// >>> hdl/clm_monitor.sv
// Lock supervision and ppm error measurement for one CDR channel
`timescale 1ns/1ps
// Overview of operation
// - Once locked, recheck failed criteria up to programmed 0..3 extra times, then drop.
// - Lock regained during rechecks keeps lock high and zeroes the check counter.
// - Scale ppm delta tolerance: x1, +bits3:1, x2, or x2 plus bits3:1.
// - Capture bit computes ppm error into two result registers, then self-clears.
// - Without trigger, ppm error result refreshes continuously.
// - Ready flag shows a ppm error count is available in result registers.
module clm_monitor
  import clm_pkg::*;
(
  input  wire logic        ref_clk,       // System clock, 50 MHz
  input  wire logic        rst,           // Synchronous reset, active high
  input  wire logic        reg_wr,        // Register write strobe
  input  wire logic        reg_rd,        // Register read strobe
  input  wire logic [7:0]  reg_addr,      // Register offset
  input  wire logic [7:0]  reg_wdata,     // Register write data
  output logic      [7:0]  reg_rdata,     // Register read data
  input  wire logic        crit_ok_pin,   // Raw lock criteria met (async)
  input  wire logic [15:0] ppm_count,     // Frequency offset count (async)
  output logic             lock_out,      // Lock indication
  output logic      [8:0]  tol_scaled     // Scaled ppm delta tolerance
);
  // Synchronisers for outside inputs
  logic        ok_s1_reg, ok_s2_reg;
  logic [15:0] cnt_s1_reg, cnt_s2_reg;

  always_ff @(posedge ref_clk) begin
    ok_s1_reg  <= crit_ok_pin;
    ok_s2_reg  <= ok_s1_reg;
    cnt_s1_reg <= ppm_count;
    cnt_s2_reg <= cnt_s1_reg;
  end

  // Enable pulses for lock checks and continuous refresh
  logic check_tick;
  logic refresh_tick;

  clm_tick #(.PERIOD(CLM_CHECK_CYC)) u_check_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (check_tick)
  );

  clm_tick #(.PERIOD(CLM_REFRESH_CYC)) u_refresh_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (refresh_tick)
  );

  // Register state
  logic [7:0]   lock_ctrl_reg, lock_ctrl_next;
  logic [7:0]   ppm_ctrl_reg, ppm_ctrl_next;
  logic [7:0]   delta_reg, delta_next;
  logic [15:0]  ppm_err_reg, ppm_err_next;
  logic         rdy_reg, rdy_next;
  logic [15:0]  hold_reg, hold_next;
  clm_lock_st_t st_reg, st_next;
  logic [1:0]   fail_cnt_reg, fail_cnt_next;
  logic         lock_reg, lock_next;
  logic         capture;
  logic [1:0]   retry_limit;
  logic [1:0]   scale;

  assign retry_limit = {lock_ctrl_reg[CLM_BIT_RETRY_HI], lock_ctrl_reg[CLM_BIT_RETRY_LO]};
  assign scale       = {ppm_ctrl_reg[CLM_BIT_SCALE_HI], ppm_ctrl_reg[CLM_BIT_SCALE_LO]};

  // Manual trigger forces a capture; otherwise refresh tick does
  assign capture = ppm_ctrl_reg[CLM_BIT_GET_PPM] || refresh_tick;

  // Register file, result capture and ready flag
  always_comb begin
    lock_ctrl_next = lock_ctrl_reg;
    ppm_ctrl_next  = ppm_ctrl_reg;
    delta_next     = delta_reg;
    ppm_err_next   = ppm_err_reg;
    rdy_next       = rdy_reg;
    hold_next      = hold_reg;
    if (reg_wr) begin
      case (reg_addr)
        CLM_OFS_LOCK_CTRL: begin
          lock_ctrl_next = reg_wdata;
          rdy_next       = reg_wdata[CLM_BIT_PPM_RDY];
        end
        CLM_OFS_PPM_CTRL:  ppm_ctrl_next = reg_wdata;
        CLM_OFS_PPM_DELTA: delta_next    = reg_wdata;
        default: ;
      endcase
    end
    // Reading the low byte freezes the high byte so both halves match
    if (reg_rd && reg_addr == CLM_OFS_PPM_ERR_LO) begin
      hold_next = ppm_err_reg;
    end
    // Capture beats a concurrent clear of the ready flag
    if (capture) begin
      ppm_err_next = cnt_s2_reg;
      rdy_next     = 1'b1;
      // A trigger written in this very cycle survives, so the request is never lost
      if (!(reg_wr && reg_addr == CLM_OFS_PPM_CTRL)) begin
        ppm_ctrl_next[CLM_BIT_GET_PPM] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_ctrl_reg <= CLM_RST_LOCK_CTRL;
      ppm_ctrl_reg  <= CLM_RST_PPM_CTRL;
      delta_reg     <= CLM_RST_DELTA;
      ppm_err_reg   <= 16'h0000;
      rdy_reg       <= 1'b0;
      hold_reg      <= 16'h0000;
    end else begin
      lock_ctrl_reg <= lock_ctrl_next;
      ppm_ctrl_reg  <= ppm_ctrl_next;
      delta_reg     <= delta_next;
      ppm_err_reg   <= ppm_err_next;
      rdy_reg       <= rdy_next;
      hold_reg      <= hold_next;
    end
  end

  // Lock supervision state machine, evaluated on each check tick
  always_comb begin
    st_next       = st_reg;
    fail_cnt_next = fail_cnt_reg;
    lock_next     = lock_reg;
    if (check_tick) begin
      case (st_reg)
        CLM_UNLOCKED: begin
          if (ok_s2_reg) begin
            st_next       = CLM_LOCKED;
            lock_next     = 1'b1;
            fail_cnt_next = 2'h0;
          end
        end
        CLM_LOCKED: begin
          if (!ok_s2_reg) begin
            if (retry_limit == 2'h0) begin
              st_next       = CLM_UNLOCKED;
              lock_next     = 1'b0;
              fail_cnt_next = 2'h0;
            end else begin
              st_next       = CLM_RECHECK;
              fail_cnt_next = 2'h1;
            end
          end
        end
        CLM_RECHECK: begin
          if (ok_s2_reg) begin
            st_next       = CLM_LOCKED;
            fail_cnt_next = 2'h0;
          end else if (fail_cnt_reg >= retry_limit) begin
            st_next       = CLM_UNLOCKED;
            lock_next     = 1'b0;
            fail_cnt_next = 2'h0;
          end else begin
            fail_cnt_next = fail_cnt_reg + 2'h1;
          end
        end
        default: begin
          st_next       = CLM_UNLOCKED;
          lock_next     = 1'b0;
          fail_cnt_next = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg       <= CLM_UNLOCKED;
      fail_cnt_reg <= 2'h0;
      lock_reg     <= 1'b0;
    end else begin
      st_reg       <= st_next;
      fail_cnt_reg <= fail_cnt_next;
      lock_reg     <= lock_next;
    end
  end

  assign lock_out = lock_reg;

  // Tolerance scaling; one extra bit keeps the doubled value from wrapping
  logic [8:0] tol_next;
  logic [8:0] tol_reg;

  always_comb begin
    case (scale)
      2'b00:   tol_next = {1'b0, delta_reg};
      2'b01:   tol_next = {1'b0, delta_reg} + {6'h00, delta_reg[3:1]};
      2'b10:   tol_next = {delta_reg, 1'b0};
      2'b11:   tol_next = {delta_reg, 1'b0} + {6'h00, delta_reg[3:1]};
      default: tol_next = {1'b0, delta_reg};
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tol_reg <= 9'h000;
    end else begin
      tol_reg <= tol_next;
    end
  end

  assign tol_scaled = tol_reg;

  // Read mux, registered; unmapped offsets read zero
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  always_comb begin
    case (reg_addr)
      CLM_OFS_LOCK_CTRL:  rdata_next = {rdy_reg, lock_ctrl_reg[6:0]};
      CLM_OFS_PPM_CTRL:   rdata_next = ppm_ctrl_reg;
      CLM_OFS_PPM_ERR_LO: rdata_next = ppm_err_reg[7:0];
      CLM_OFS_PPM_ERR_HI: rdata_next = hold_reg[15:8];
      CLM_OFS_PPM_DELTA:  rdata_next = delta_reg;
      default:            rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule

// >>> bench/clm_monitor_props.sv
// Checker of lock, tolerance and capture behaviour at the monitor ports
`timescale 1ns/1ps
module clm_monitor_chk
  import clm_pkg::*;
(
  input wire logic        ref_clk,      // Clock
  input wire logic        rst,          // Reset
  input wire logic        reg_wr,       // Write strobe
  input wire logic        reg_rd,       // Read strobe
  input wire logic [7:0]  reg_addr,     // Offset
  input wire logic [7:0]  reg_wdata,    // Write data
  input wire logic [7:0]  reg_rdata,    // Read data
  input wire logic        crit_ok_pin,  // Criteria met
  input wire logic [15:0] ppm_count,    // Offset count
  input wire logic        lock_out,     // Lock
  input wire logic [8:0]  tol_scaled    // Tolerance
);
  logic [1:0] lim;
  logic [1:0] scl;
  logic [7:0] dlt;
  logic [9:0] lo;
  logic [8:0] tol_e;
  // Shadows of writes; lo saturates so a long loss never wraps into the window
  always_ff @(posedge ref_clk) begin
    lim <= rst ? CLM_RST_LOCK_CTRL[5:4]
         : (reg_wr && reg_addr == CLM_OFS_LOCK_CTRL) ? reg_wdata[5:4] : lim;
    scl <= rst ? CLM_RST_PPM_CTRL[7:6]
         : (reg_wr && reg_addr == CLM_OFS_PPM_CTRL) ? reg_wdata[7:6] : scl;
    dlt <= rst ? CLM_RST_DELTA
         : (reg_wr && reg_addr == CLM_OFS_PPM_DELTA) ? reg_wdata : dlt;
    lo  <= (rst || crit_ok_pin) ? 10'h000 : lo + {9'h000, lo != 10'h3ff};
  end
  // Expected tolerance from the scale code
  assign tol_e = (scl[1] ? {dlt, 1'b0} : {1'b0, dlt}) + (scl[0] ? {6'h00, dlt[3:1]} : 9'h000);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst;
    $fell(rst) |-> !lock_out && reg_rdata == 8'h00 && tol_scaled == 9'h000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_hold;
    lock_out && crit_ok_pin && $past(crit_ok_pin) && $past(crit_ok_pin, 2) |=> lock_out;
  endproperty
  a_hold: assert property (p_hold) else $error("lock dropped while criteria held");
  property p_fall;
    $fell(lock_out) |-> lo >= 10'(50 * lim + 2) && lo <= 10'(50 * lim + 55);
  endproperty
  a_fall: assert property (p_fall) else $error("lock dropped after wrong check count");
  // The pin reaches the lock logic two flops late and lock registers one edge after that
  property p_rise; $rose(lock_out) |-> $past(crit_ok_pin, 3); endproperty
  a_rise: assert property (p_rise) else $error("lock rose without criteria");
  property p_tol;
    !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2) |-> tol_scaled == tol_e;
  endproperty
  a_tol: assert property (p_tol) else $error("scaled tolerance wrong");
  property p_tol_wr; $changed(tol_scaled) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
  a_tol_wr: assert property (p_tol_wr) else $error("tolerance moved without a write");
  sequence s_get; reg_wr && reg_addr == CLM_OFS_PPM_CTRL && reg_wdata[CLM_BIT_GET_PPM]; endsequence
  property p_get;
    s_get ##1 (reg_addr == CLM_OFS_PPM_CTRL) [*5] |-> !reg_rdata[CLM_BIT_GET_PPM];
  endproperty
  a_get: assert property (p_get) else $error("capture bit did not clear");
  c_drop: cover property ($fell(lock_out) && lim == 2'h3);
  c_regain: cover property (lock_out && $rose(crit_ok_pin));
  c_get: cover property (s_get);
  c_read: cover property (reg_rd && reg_addr == CLM_OFS_PPM_ERR_LO);
endmodule
bind clm_monitor clm_monitor_chk u_chk (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .crit_ok_pin, .ppm_count, .lock_out, .tol_scaled);

// >>> bench/clm_src.sv
// Stand-in for the serial stream source feeding criteria and offset count
`timescale 1ns/1ps
module clm_src (
  input  wire logic        ref_clk,      // Clock
  input  wire logic        ok_req,       // Wanted criteria state
  input  wire logic [15:0] ppm_req,      // Wanted offset count
  output logic             crit_ok_pin,  // Criteria met
  output logic      [15:0] ppm_count     // Offset count
);
  // Registered, so the stream answers one cycle late like a slow source
  always_ff @(posedge ref_clk) begin
    crit_ok_pin <= ok_req;
    ppm_count   <= ppm_req;
  end
endmodule

// >>> bench/cdr_lock_ppm_monitor_tb.sv
// Self-checking bench of the lock supervision and ppm measurement block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module cdr_lock_ppm_monitor_tb;
  import clm_pkg::*;
  logic        ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ok_req = 0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rdv, reg_rdata;
  logic [15:0] ppm_req = 16'h0000, ppm_count;
  logic        crit_ok_pin, lock_out;
  logic [8:0]  tol_scaled;
  int          n_errors = 0, total_checks = 0, cyc = 0, d, lim;
  int          exp_q[$];
  always #10 ref_clk = ~ref_clk;
  clm_src u_src (.ref_clk, .ok_req, .ppm_req, .crit_ok_pin, .ppm_count);
  clm_monitor u_dut (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .crit_ok_pin, .ppm_count, .lock_out, .tol_scaled);
  task conclude;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well beyond the roughly 3100 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_errors++;
      conclude();
    end
  end
  task cy(input int n); repeat (n) @(posedge ref_clk); #1; endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk); #1 reg_addr = a; reg_wdata = v; reg_wr = 1;
    @(posedge ref_clk); #1 reg_wr = 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk); #1 reg_addr = a; reg_rd = 1;
    @(posedge ref_clk); #1 reg_rd = 0; rdv = reg_rdata;
  endtask
  // Reference tolerance: doubled by the high code bit, plus base bits 3:1 by the low one
  function int tol_m(int dl, int sc);
    return (sc / 2 + 1) * dl + (sc % 2) * ((dl >> 1) & 7);
  endfunction
  initial begin
    void'($urandom(86));
    cy(4); rst = 0;
    // The first refresh lands one cycle after reset, so ready is already up here
    rd(CLM_OFS_LOCK_CTRL);
    `CHK(rdv[6:0], CLM_RST_LOCK_CTRL[6:0])
    `CHK(rdv[CLM_BIT_PPM_RDY], 1'b1)
    rd(CLM_OFS_PPM_CTRL); `CHK(rdv, CLM_RST_PPM_CTRL)
    // Every scale code with a random base kept clear of nine-bit overflow
    for (int s = 0; s < 4; s++) begin
      d = $urandom % 249; wr(CLM_OFS_PPM_DELTA, 8'(d)); wr(CLM_OFS_PPM_CTRL, 8'(s * 64 + 31));
      cy(3); `CHK(tol_scaled, 9'(tol_m(d, s)))
    end
    // Each retry limit: still locked after lim checks, dropped one check later
    for (lim = 0; lim < 4; lim++) begin
      wr(CLM_OFS_LOCK_CTRL, 8'(lim * 16 + 15)); ok_req = 1; cy(120);
      `CHK(lock_out, 1'b1)
      ok_req = 0; cy(50 * lim); `CHK(lock_out, 1'b1)
      cy(60); `CHK(lock_out, 1'b0)
    end
    // Short loss, regain, then a full loss must start the count afresh
    ok_req = 1; cy(120); ok_req = 0; cy(60); ok_req = 1; cy(50); ok_req = 0;
    cy(140); `CHK(lock_out, 1'b1)
    cy(70); `CHK(lock_out, 1'b0)
    // Free-running refresh, low byte read first to freeze the high byte
    ppm_req = 16'($urandom); exp_q.push_back(ppm_req); cy(1100);
    rd(CLM_OFS_PPM_ERR_LO); `CHK(rdv, 8'(exp_q[0]))
    rd(CLM_OFS_PPM_ERR_HI); `CHK(rdv, 8'(exp_q[0] >> 8))
    // Manual capture away from the refresh phase, so only the trigger can load the result
    while (cyc % CLM_REFRESH_CYC != 100) begin
      cy(1);
    end
    ppm_req = 16'($urandom); exp_q.push_back(ppm_req); cy(6);
    wr(CLM_OFS_LOCK_CTRL, 8'h3f);
    rd(CLM_OFS_LOCK_CTRL); `CHK(rdv[CLM_BIT_PPM_RDY], 1'b0)
    wr(CLM_OFS_PPM_CTRL, 8'h3f); cy(4);
    rd(CLM_OFS_PPM_CTRL); `CHK(rdv[CLM_BIT_GET_PPM], 1'b0)
    rd(CLM_OFS_LOCK_CTRL); `CHK(rdv[CLM_BIT_PPM_RDY], 1'b1)
    rd(CLM_OFS_PPM_ERR_LO); `CHK(rdv, 8'(exp_q[1]))
    rd(CLM_OFS_PPM_ERR_HI); `CHK(rdv, 8'(exp_q[1] >> 8))
    conclude();
  end
endmodule
